// ===== rtl/dtc_pkg.sv
// dtc_pkg: constants and types shared by the dual timer/counter design.
// assumes one system clock domain; no bus, every control bit is a port.
`default_nettype none

package dtc_pkg;

    // operating modes, two-bit field per timer
    typedef enum logic [1:0] {
        DTC_MODE_VAR   = 2'h0,
        DTC_MODE_AR16  = 2'h1,
        DTC_MODE_AR8   = 2'h2,
        DTC_MODE_SPLIT = 2'h3
    } dtc_mode_type;

    // mode register layout: one nibble per timer, timer 1 in the upper nibble
    localparam int unsigned DTC_FIELD_STRIDE = 4;
    localparam int unsigned DTC_MODE_POS     = 0;
    localparam int unsigned DTC_CT_POS       = 2;
    localparam int unsigned DTC_GATE_POS     = 3;

    // mode 0 width field: active low-byte bits = field + 1
    localparam logic [2:0] DTC_PSC_WIDTH_RESET = 3'h4;
    localparam logic [2:0] DTC_PSC_MAX         = 3'h7;

    // reset values
    localparam logic [7:0] DTC_COUNT_RESET  = 8'h00;
    localparam logic [7:0] DTC_RELOAD_RESET = 8'h00;
    localparam logic [3:0] DTC_TPS_RESET    = 4'h0;

    // software byte-write selectors
    localparam logic [2:0] DTC_SEL_LOW0  = 3'h0;
    localparam logic [2:0] DTC_SEL_LOW1  = 3'h1;
    localparam logic [2:0] DTC_SEL_HIGH0 = 3'h2;
    localparam logic [2:0] DTC_SEL_HIGH1 = 3'h3;
    localparam logic [2:0] DTC_SEL_RL0   = 3'h4;
    localparam logic [2:0] DTC_SEL_RL1   = 3'h5;
    localparam logic [2:0] DTC_SEL_RH0   = 3'h6;
    localparam logic [2:0] DTC_SEL_RH1   = 3'h7;

endpackage : dtc_pkg

`default_nettype wire

// ===== rtl/dtc_evt_if.sv
// dtc_evt_if: count events passed from the helpers into the timer core.
// assumes all signals are on clk_sys.
`default_nettype none

interface dtc_evt_if;
    logic       tick;
    logic [1:0] countEdge;
    logic [1:0] gateLevel;

    modport presc (output tick);
    modport pins  (output countEdge, output gateLevel);
    modport core  (input tick, input countEdge, input gateLevel);
endinterface : dtc_evt_if

`default_nettype wire

// ===== rtl/dtc_prescaler.sv
// dtc_prescaler: shared divider giving one timer tick every divide+1 clocks.
// assumes clk_sys, synchronous active-low reset, ce freezing the count.
`default_nettype none

module dtc_prescaler
    import dtc_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic [3:0] divide,
    dtc_evt_if.presc        evt
);
    logic [3:0] div_q;
    logic [3:0] div_d;
    wire        tickNow = (div_q >= divide);

    // compare with >= so a smaller divide taking effect mid-count recovers
    assign div_d    = tickNow ? DTC_TPS_RESET : div_q + 4'h1;
    assign evt.tick = tickNow; // RULE2

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            div_q <= DTC_TPS_RESET;
        end else if (ce) begin
            div_q <= div_d;
        end
    end
endmodule : dtc_prescaler

`default_nettype wire

// ===== rtl/dtc_pin_sync.sv
// dtc_pin_sync: synchronises count and gate pins, detects falling count edges.
// assumes pins are asynchronous to clk_sys; port bits are already on clk_sys.
`default_nettype none

module dtc_pin_sync
    import dtc_pkg::*;
#(
    parameter bit HAS_COUNT_PINS = 1'b1
) (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       ce,
    input  wire logic [1:0] countPin,
    input  wire logic [1:0] gatePin,
    input  wire logic [1:0] portCountBit,
    dtc_evt_if.pins         evt
);
    for (genvar i = 0; i < 2; i++) begin : g_ch
        logic cntMeta_q;
        logic cntSync_q;
        logic gateMeta_q;
        logic gateSync_q;
        logic last_q;
        wire  cur;

        // without count pins, software port bits stand in, no sync needed
        assign cur = HAS_COUNT_PINS ? cntSync_q : portCountBit[i]; // RULE24
        assign evt.countEdge[i] = last_q & ~cur; // RULE3
        assign evt.gateLevel[i] = gateSync_q;

        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                cntMeta_q  <= 1'b0;
                cntSync_q  <= 1'b0;
                gateMeta_q <= 1'b0;
                gateSync_q <= 1'b0;
                last_q     <= 1'b0;
            end else if (ce) begin
                cntMeta_q  <= countPin[i]; // RULE26
                cntSync_q  <= cntMeta_q;
                gateMeta_q <= gatePin[i]; // RULE26
                gateSync_q <= gateMeta_q;
                last_q     <= cur; // RULE3
            end
        end
    end
endmodule : dtc_pin_sync

`default_nettype wire

// ===== rtl/dtc_timer_core.sv
// dtc_timer_core: two 16-bit timer/counters with four modes each.
// assumes software drives control ports on clk_sys and pins are asynchronous.
// Notes on behaviour
// RULE1 - timer mode counts every enabled system clock
// RULE2 - shared prescaler divides rate by one to sixteen
// RULE3 - counter samples input, counts high-then-low samples
// RULE4 - count visible the cycle after edge detection
// RULE5 - external input holds each level one cycle
// RULE6 - per-timer source bit and two-bit mode field
// RULE7 - modes: variable, 16-bit reload, 8-bit reload, split
// RULE8 - mode 0: high byte plus 1-8 prescale bits
// RULE9 - default mode 0 is 13-bit counter
// RULE10 - active prescale bits equal width field plus one
// RULE11 - unused upper low-byte bits are indeterminate
// RULE12 - rollover to zero sets overflow flag
// RULE13 - count only when run and gate allow
// RULE14 - gate bits at mode bits 7 and 3
// RULE15 - starting run keeps the current count
// RULE16 - gate inputs usable only on RC oscillator
// RULE17 - mode 1: 16-bit count, reload pair on overflow
// RULE18 - reload pairs reset to zero
// RULE19 - mode 2: low byte reloads from high byte
// RULE20 - unused reload pair is plain storage
// RULE21 - timer 1 in mode 3 holds count
// RULE22 - split: high byte uses timer 1 run, flag
// RULE23 - split: timer 1 runs but raises no flag
// RULE24 - port bits replace missing count pins
// RULE25 - flag cleared when interrupt is vectored
// RULE26 - count and gate pins synchronised first
`default_nettype none

module dtc_timer_core
    import dtc_pkg::*;
#(
    parameter bit HAS_COUNT_PINS = 1'b1
) (
    input  wire logic            clk_sys,
    input  wire logic            nrst,
    input  wire logic            ce,
    input  wire logic [1:0]      countPin,
    input  wire logic [1:0]      gatePin,
    input  wire logic [1:0]      portCountBit,
    input  wire logic            rcOscSelected,
    input  wire logic [1:0]      runControl,
    input  wire logic [7:0]      timerModeReg,
    input  wire logic [2:0]      prescaleWidth0,
    input  wire logic [2:0]      prescaleWidth1,
    input  wire logic [3:0]      systemTimerPrescaler,
    input  wire logic            wrEn,
    input  wire logic [2:0]      wrSel,
    input  wire logic [7:0]      wrData,
    input  wire logic [1:0]      vectorAck,
    output logic      [1:0][7:0] countLow_q,
    output logic      [1:0][7:0] countHigh_q,
    output logic      [1:0][7:0] reloadLow_q,
    output logic      [1:0][7:0] reloadHigh_q,
    output logic      [1:0]      overflowFlag_q
);
    dtc_evt_if evt ();

    dtc_prescaler u_presc (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .divide  (systemTimerPrescaler),
        .evt     (evt)
    );

    dtc_pin_sync #(
        .HAS_COUNT_PINS (HAS_COUNT_PINS)
    ) u_pins (
        .clk_sys      (clk_sys),
        .nrst         (nrst),
        .ce           (ce),
        .countPin     (countPin),
        .gatePin      (gatePin),
        .portCountBit (portCountBit),
        .evt          (evt)
    );

    logic [1:0] ovf;
    logic [1:0] hiOvf;
    wire        splitMode0;

    assign splitMode0 = timerModeReg[DTC_MODE_POS +: 2] == DTC_MODE_SPLIT;

    for (genvar i = 0; i < 2; i++) begin : g_tmr
        localparam int unsigned BASE = i * DTC_FIELD_STRIDE;
        dtc_mode_type md;
        logic [7:0]   lowNext;
        logic [7:0]   highNext;
        wire  [2:0]   prescale_width_field;
        wire  [7:0]   mask;
        wire  [7:0]   low;
        wire  [7:0]   high;
        wire          ctSel;
        wire          gateOn;
        wire          gateLvl;
        wire          stopped;
        wire          run;
        wire          step;
        wire          lowFull;
        wire          wrLow;
        wire          wrHigh;
        wire          wrRl;
        wire          wrRh;

        assign md      = dtc_mode_type'(timerModeReg[BASE + DTC_MODE_POS +: 2]); // RULE6
        assign ctSel   = timerModeReg[BASE + DTC_CT_POS]; // RULE6
        assign gateOn  = timerModeReg[BASE + DTC_GATE_POS]; // RULE14
        assign prescale_width_field     = (i == 0) ? prescaleWidth0 : prescaleWidth1;
        // field+1 active bits: mask of (psc+1) ones
        assign mask    = 8'hff >> (DTC_PSC_MAX - prescale_width_field); // RULE10 RULE8 RULE9
        assign low     = countLow_q[i];
        assign high    = countHigh_q[i];
        // gate pins double as crystal pins; off the RC source the gate reads high
        assign gateLvl = rcOscSelected ? evt.gateLevel[i] : 1'b1; // RULE16
        assign stopped = (i == 1) && (md == DTC_MODE_SPLIT); // RULE21 RULE23
        assign run     = runControl[i] & (~gateOn | gateLvl) & ~stopped; // RULE13
        assign step    = run & (ctSel ? evt.countEdge[i] : evt.tick); // RULE1 RULE4
        assign lowFull = (low & mask) == mask;

        always_comb begin
            lowNext  = low;
            highNext = high;
            ovf[i]   = 1'b0;
            hiOvf[i] = 1'b0;
            case (md) // RULE7
                DTC_MODE_VAR: begin
                    if (step && lowFull) begin
                        // upper inactive bits left alone, software ignores them
                        lowNext  = low & ~mask; // RULE11
                        highNext = high + 8'h01; // RULE8
                        ovf[i]   = high == 8'hff; // RULE12
                    end else if (step) begin
                        lowNext = (low & ~mask) | ((low + 8'h01) & mask); // RULE8
                    end
                end
                DTC_MODE_AR16: begin
                    if (step && {high, low} == 16'hffff) begin
                        lowNext  = reloadLow_q[i]; // RULE17
                        highNext = reloadHigh_q[i];
                        ovf[i]   = 1'b1; // RULE12
                    end else if (step) begin
                        {highNext, lowNext} = {high, low} + 16'h0001; // RULE17
                    end
                end
                DTC_MODE_AR8: begin
                    if (step && low == 8'hff) begin
                        lowNext = high; // RULE19
                        ovf[i]  = 1'b1;
                    end else if (step) begin
                        lowNext = low + 8'h01;
                    end
                end
                default: begin
                    if (i == 0) begin
                        if (step) begin
                            lowNext = low + 8'h01; // RULE22
                            ovf[i]  = low == 8'hff;
                        end
                        // high byte: clock ticks only, timer 1 run bit
                        if (evt.tick && runControl[1]) begin
                            highNext = high + 8'h01; // RULE22
                            hiOvf[i] = high == 8'hff;
                        end
                    end
                end
            endcase
        end

        // a software write wins over a count step in the same cycle
        assign wrLow  = wrEn && wrSel == ((i == 0) ? DTC_SEL_LOW0  : DTC_SEL_LOW1);
        assign wrHigh = wrEn && wrSel == ((i == 0) ? DTC_SEL_HIGH0 : DTC_SEL_HIGH1);
        assign wrRl   = wrEn && wrSel == ((i == 0) ? DTC_SEL_RL0   : DTC_SEL_RL1);
        assign wrRh   = wrEn && wrSel == ((i == 0) ? DTC_SEL_RH0   : DTC_SEL_RH1);

        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                countLow_q[i]   <= DTC_COUNT_RESET;
                countHigh_q[i]  <= DTC_COUNT_RESET;
                reloadLow_q[i]  <= DTC_RELOAD_RESET; // RULE18
                reloadHigh_q[i] <= DTC_RELOAD_RESET; // RULE18
            end else if (ce) begin
                // run bit only gates steps, counts never cleared by it
                countLow_q[i]   <= wrLow  ? wrData : lowNext; // RULE15
                countHigh_q[i]  <= wrHigh ? wrData : highNext;
                if (wrRl) begin
                    reloadLow_q[i] <= wrData; // RULE20
                end
                if (wrRh) begin
                    reloadHigh_q[i] <= wrData; // RULE20
                end
            end
        end
    end

    // timer 1 flag: taken over by split high byte while timer 0 is in mode 3
    wire [1:0] flagSet;
    assign flagSet[0] = ovf[0];
    assign flagSet[1] = splitMode0 ? hiOvf[0] : ovf[1]; // RULE22 RULE23

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            overflowFlag_q <= 2'h0;
        end else if (ce) begin
            // set beats a vector clear landing in the same cycle
            overflowFlag_q <= flagSet | (overflowFlag_q & ~vectorAck); // RULE25 RULE12
        end
    end
endmodule : dtc_timer_core

`default_nettype wire

// ===== testbench/dtc_timer_core_props.sv
// dtc_timer_core_props: port-level checks for the dual timer/counter.
// assumes one clock domain and a sync active-low reset; bound below.
`default_nettype none

module dtc_timer_core_props
    import dtc_pkg::*;
(
    input wire logic            clk_sys,
    input wire logic            nrst,
    input wire logic            ce,
    input wire logic [1:0]      countPin,
    input wire logic [1:0]      gatePin,
    input wire logic [1:0]      portCountBit,
    input wire logic            rcOscSelected,
    input wire logic [1:0]      runControl,
    input wire logic [7:0]      timerModeReg,
    input wire logic [2:0]      prescaleWidth0,
    input wire logic [2:0]      prescaleWidth1,
    input wire logic [3:0]      systemTimerPrescaler,
    input wire logic            wrEn,
    input wire logic [2:0]      wrSel,
    input wire logic [7:0]      wrData,
    input wire logic [1:0]      vectorAck,
    input wire logic [1:0][7:0] countLow_q,
    input wire logic [1:0][7:0] countHigh_q,
    input wire logic [1:0][7:0] reloadLow_q,
    input wire logic [1:0][7:0] reloadHigh_q,
    input wire logic [1:0]      overflowFlag_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire logic [15:0] cnt0 = {countHigh_q[0], countLow_q[0]};
    wire logic        split0 = timerModeReg[1:0] == DTC_MODE_SPLIT;

    a_count_rate: assert property (ce && runControl[0] && timerModeReg[3:0] == 4'h1
        && systemTimerPrescaler == 4'h0 && !wrEn && cnt0 != 16'hffff
        |=> cnt0 == $past(cnt0) + 16'h1) else $error("timer 0 missed a step");
    a_run_off: assert property (ce && !runControl[0] && !wrEn && !split0
        |=> $stable(cnt0)) else $error("timer 0 moved while stopped");
    a_hold_t1: assert property (timerModeReg[5:4] == 2'h3 && !wrEn
        |=> $stable(countLow_q[1]) && $stable(countHigh_q[1])) else $error("timer 1 moved");
    a_reload_store: assert property (!wrEn
        |=> $stable(reloadLow_q) && $stable(reloadHigh_q)) else $error("reload changed");
    a_write_reload: assert property (wrEn && ce && wrSel == DTC_SEL_RH1
        |=> reloadHigh_q[1] == $past(wrData)) else $error("reload write lost");
    a_reload_sixteen: assert property ($rose(overflowFlag_q[0])
        && timerModeReg[1:0] == DTC_MODE_AR16
        |-> cnt0 == {reloadHigh_q[0], reloadLow_q[0]}) else $error("no 16-bit reload");
    a_reload_eight: assert property ($rose(overflowFlag_q[0])
        && timerModeReg[1:0] == DTC_MODE_AR8
        |-> countLow_q[0] == countHigh_q[0]) else $error("no 8-bit reload");
    a_split_flag: assert property ($rose(overflowFlag_q[1]) && split0
        |-> countHigh_q[0] == 8'h00) else $error("flag 1 not from high byte");
    a_ack_clear: assert property (ce && vectorAck[0] && !runControl[0] && !split0
        |=> !overflowFlag_q[0]) else $error("flag 0 not cleared");
endmodule : dtc_timer_core_props

bind dtc_timer_core dtc_timer_core_props u_props (.*);

`default_nettype wire

// ===== testbench/dtc_pin_model.sv
// dtc_pin_model: drives the external count and gate pins.
// assumes levels change 1 ns after a clk_sys edge.
`default_nettype none

module dtc_pin_model (
    input  wire logic       clk_sys,
    output var  logic [1:0] countPin,
    output var  logic [1:0] gatePin
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        countPin = 2'h3;
        gatePin  = 2'h3;
    end
    // two cycles per level, margin over the one-cycle minimum
    task automatic pulses(input int idx, input int n);
        repeat (n) begin
            countPin[idx] = 1'b0;
            repeat (2) @(posedge clk_sys);
            #1 countPin[idx] = 1'b1;
            repeat (2) @(posedge clk_sys);
            #1;
        end
    endtask : pulses
    task automatic gate(input int idx, input logic lvl);
        gatePin[idx] = lvl;
    endtask : gate
endmodule : dtc_pin_model

`default_nettype wire

// ===== testbench/tb_top.sv
// tb_top: self-checking bench for the dual timer/counter.
// assumes the pin model drives count and gate pins; 4 ns clock.
`default_nettype none

module tb_top
    import dtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic            clk_sys = 1'b0, nrst = 1'b0, ce = 1'b1, rcOscSelected = 1'b1, wrEn = 1'b0;
    logic [1:0]      countPin, gatePin, overflowFlag_q;
    logic [1:0]      portCountBit = 2'h0, runControl = 2'h0, vectorAck = 2'h0;
    logic [7:0]      timerModeReg = 8'h00, wrData = 8'h00;
    logic [2:0]      prescaleWidth0 = 3'h4, prescaleWidth1 = 3'h4, wrSel = 3'h0;
    logic [3:0]      systemTimerPrescaler = 4'h0;
    logic [1:0][7:0] countLow_q, countHigh_q, reloadLow_q, reloadHigh_q;
    int              fail_count = 0, cmp_count = 0;
    logic [1:0][7:0] swLow;

    always #2 clk_sys = ~clk_sys;
    dtc_timer_core dut (.*);
    dtc_pin_model pins (.*);
    // second core without count pins: port bits stand in for the count inputs
    dtc_timer_core #(
        .HAS_COUNT_PINS (1'b0)
    ) dut_sw (
        .clk_sys              (clk_sys),
        .nrst                 (nrst),
        .ce                   (ce),
        .countPin             (countPin),
        .gatePin              (gatePin),
        .portCountBit         (portCountBit),
        .rcOscSelected        (rcOscSelected),
        .runControl           (runControl),
        .timerModeReg         (timerModeReg),
        .prescaleWidth0       (prescaleWidth0),
        .prescaleWidth1       (prescaleWidth1),
        .systemTimerPrescaler (systemTimerPrescaler),
        .wrEn                 (wrEn),
        .wrSel                (wrSel),
        .wrData               (wrData),
        .vectorAck            (vectorAck),
        .countLow_q           (swLow),
        .countHigh_q          (),
        .reloadLow_q          (),
        .reloadHigh_q         (),
        .overflowFlag_q       ()
    );

    task automatic step(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // idle cycle after each write keeps strobes one assignment per step
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        wrEn = 1'b1;
        wrSel = sel;
        wrData = d;
        step();
        wrEn = 1'b0;
        step();
    endtask : wr
    task automatic run(input int idx, input int n);
        runControl[idx] = 1'b1;
        step(n);
        runControl[idx] = 1'b0;
    endtask : run
    task automatic ack(input int idx);
        vectorAck[idx] = 1'b1;
        step();
        vectorAck[idx] = 1'b0;
        step();
    endtask : ack
    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report

    initial begin
        step(5000);
        fail_count++;
        final_report();
    end

    initial begin
        logic [7:0] mask;
        step(20);
        nrst = 1'b1;
        step();
        chk("reload", {reloadHigh_q, reloadLow_q}, 32'h0);
        wr(DTC_SEL_RH1, 8'h5a);
        chk("rh1", reloadHigh_q[1], 8'h5a);
        wr(DTC_SEL_RL0, 8'hf0);
        wr(DTC_SEL_RH0, 8'hff);
        wr(DTC_SEL_LOW0, 8'hfe);
        wr(DTC_SEL_HIGH0, 8'hff);
        timerModeReg = 8'h01;
        run(0, 3);
        chk("m1 count", {countHigh_q[0], countLow_q[0]}, 16'hfff1);
        chk("m1 flag", overflowFlag_q[0], 1'b1);
        ack(0);
        chk("ack", overflowFlag_q[0], 1'b0);
        wr(DTC_SEL_HIGH0, 8'hfd);
        wr(DTC_SEL_LOW0, 8'hfe);
        timerModeReg = 8'h02;
        run(0, 2);
        chk("m2 low", countLow_q[0], 8'hfd);
        chk("m2 high", countHigh_q[0], 8'hfd);
        ack(0);
        timerModeReg = 8'h00;
        for (int w = 0; w < 8; w++) begin
            mask = 8'((1 << (w + 1)) - 1);
            prescaleWidth0 = 3'(w);
            wr(DTC_SEL_LOW0, mask - 8'h1);
            wr(DTC_SEL_HIGH0, 8'hff);
            run(0, 2);
            chk("m0 high", countHigh_q[0], 8'h00);
            chk("m0 low", countLow_q[0] & mask, 8'h00);
            chk("m0 flag", overflowFlag_q[0], 1'b1);
            ack(0);
        end
        timerModeReg = 8'h33;
        wr(DTC_SEL_HIGH0, 8'hff);
        wr(DTC_SEL_LOW1, 8'h77);
        run(1, 1);
        chk("split high", countHigh_q[0], 8'h00);
        chk("split flag", overflowFlag_q, 2'h2);
        chk("t1 held", countLow_q[1], 8'h77);
        ack(1);
        wr(DTC_SEL_LOW1, 8'hff);
        wr(DTC_SEL_HIGH1, 8'hff);
        timerModeReg = 8'h13;
        run(1, 1);
        chk("t1 reload", {countHigh_q[1], countLow_q[1]}, 16'h5a00);
        chk("no flag", overflowFlag_q[1], 1'b0);
        timerModeReg = 8'h50;
        wr(DTC_SEL_LOW1, 8'h00);
        wr(DTC_SEL_HIGH1, 8'h00);
        runControl[1] = 1'b1;
        pins.pulses(1, 3);
        step(6);
        // port bit has no sync stage: high at one edge, low at the next counts
        portCountBit[1] = 1'b1;
        step();
        portCountBit[1] = 1'b0;
        chk("port early", swLow[1], 8'h00);
        step();
        chk("port edge", swLow[1], 8'h01);
        runControl[1] = 1'b0;
        chk("edges", {countHigh_q[1], countLow_q[1]}, 16'h0003);
        timerModeReg = 8'h90;
        pins.gate(1, 1'b0);
        step(4);
        run(1, 6);
        chk("t1 gated", countLow_q[1], 8'h03);
        pins.gate(1, 1'b1);
        step(4);
        run(1, 2);
        chk("t1 open", countLow_q[1], 8'h05);
        timerModeReg = 8'h09;
        wr(DTC_SEL_LOW0, 8'h00);
        wr(DTC_SEL_HIGH0, 8'h00);
        pins.gate(0, 1'b0);
        step(4);
        run(0, 10);
        chk("gated", countLow_q[0], 8'h00);
        pins.gate(0, 1'b1);
        step(4);
        run(0, 5);
        chk("gate open", countLow_q[0], 8'h05);
        pins.gate(0, 1'b0);
        rcOscSelected = 1'b0;
        step(4);
        run(0, 4);
        chk("gate unused", countLow_q[0], 8'h09);
        ce = 1'b0;
        run(0, 4);
        ce = 1'b1;
        chk("frozen", countLow_q[0], 8'h09);
        timerModeReg = 8'h01;
        systemTimerPrescaler = 4'h3;
        wr(DTC_SEL_LOW0, 8'h00);
        wr(DTC_SEL_HIGH0, 8'h00);
        // any tick phase gives ten ticks in forty cycles
        run(0, 40);
        chk("divided", countLow_q[0], 8'h0a);
        nrst = 1'b0;
        step(2);
        nrst = 1'b1;
        step();
        chk("reset again", {reloadHigh_q, countLow_q}, 32'h0);
        final_report();
    end
endmodule : tb_top

`default_nettype wire
